// ==== apb_core_model.sv ====
// processor core model: issues apb register reads and writes
// assumes the eeprom controller answers on the same clock
`timescale 1ns/1ns
`default_nettype none
module apb_core_model
(
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== data_eeprom_access_control_bench.sv ====
// self-checking bench for the eeprom controller
// assumes apb_core_model as the processor side
`timescale 1ns/1ns
`default_nettype none
module data_eeprom_access_control_bench;
    import eeprom_ctl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ext_rdata, a, d, ext_addr = 8'h00;
    logic [31:0] pwdata, prdata;
    logic data_protect_fuse_n = 1'b1, ext_req = 1'b0, ext_denied, irq;
    int errors = 0, checks_done = 0, seed = 30;
    always #4 clk = ~clk;
    apb_core_model i_apb_core_model (.clk(clk), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    eeprom_ctl #(.WRITE_COUNT(20), .POWERUP_COUNT(40)) i_eeprom_ctl (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_req(ext_req),
        .data_protect_fuse_n(data_protect_fuse_n), .ext_addr(ext_addr),
        .ext_rdata(ext_rdata), .ext_denied(ext_denied), .irq(irq));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctl(input logic p, input logic w);
        return (32'(p) << BIT_PERMIT) | (32'(w) << BIT_WRITE);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] x);
        checks_done++;
        if (seen !== x)
        begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, x);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        logic [31:0] r;
        logic        e;
        i_apb_core_model.xfer(1'b1, ad, v, r, e);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        i_apb_core_model.xfer(1'b0, ad, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic unlock(input logic p);
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        wr(OFS_CONTROL, ctl(p, 1'b1));
    endtask
    task automatic wait_idle();
        logic [31:0] r;
        logic        e;
        r = 32'h2;
        for (int k = 0; k < 50 && r[BIT_WRITE]; k++)
            i_apb_core_model.xfer(1'b0, OFS_CONTROL, 32'h0, r, e);
    endtask
    task automatic probe(input logic [7:0] x, input logic den);
        ext_req <= 1'b1;
        ext_addr <= a;
        @(posedge clk);
        ext_req <= 1'b0;
        @(posedge clk);
        chk({24'h0, ext_rdata}, {24'h0, x});
        chk({31'h0, ext_denied}, {31'h0, den});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, ctl(1'b1, 1'b0));
        unlock(1'b1);
        rdc(OFS_CONTROL, ctl(1'b1, 1'b0));
        repeat (40) @(posedge clk);
        wr(OFS_CONTROL, 32'h0);
        unlock(1'b0);
        rdc(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, ctl(1'b1, 1'b0));
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_DATA, 32'h0);
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        wr(OFS_CONTROL, ctl(1'b1, 1'b1));
        rdc(OFS_CONTROL, ctl(1'b1, 1'b0));
        rdc(8'h18, 32'h0);
        rdc(OFS_KEY, 32'h0);
        $display("guard tests done");
        for (int i = 0; i < 3; i++)
        begin
            a = 8'($random(seed));
            d = 8'($random(seed));
            wr(OFS_MASK, {31'h0, i != 2});
            wr(OFS_ADDRESS, {24'h0, a});
            wr(OFS_DATA, {24'h0, d});
            wr(OFS_CONTROL, ctl(1'b1, 1'b0));
            unlock(1'b1);
            rdc(OFS_CONTROL, ctl(1'b1, 1'b1));
            if (i == 1)
                wr(OFS_CONTROL, 32'h0);
            wait_idle();
            rdc(OFS_CONTROL, ctl(i != 1, 1'b0));
            rdc(OFS_STATUS, 32'h1);
            chk({31'h0, irq}, {31'h0, i != 2});
            wr(OFS_ADDRESS, {24'h0, a});
            wr(OFS_CONTROL, 32'h1);
            rdc(OFS_DATA, {24'h0, d});
            wr(OFS_ADDRESS, {24'h0, a + 8'h1});
            wr(OFS_CONTROL, 32'h1 | (32'h1 << (i[0] ? BIT_PROG : BIT_CFG)));
            rdc(OFS_DATA, {24'h0, d});
            wr(OFS_STATUS, 32'h1);
            rdc(OFS_STATUS, 32'h0);
            chk({31'h0, irq}, 32'h0);
            $display("write test %0d done", i);
        end
        data_protect_fuse_n <= 1'b0;
        repeat (4) @(posedge clk);
        wr(OFS_ADDRESS, {24'h0, a});
        wr(OFS_CONTROL, 32'h1);
        rdc(OFS_DATA, {24'h0, d});
        probe(8'h00, 1'b1);
        data_protect_fuse_n <= 1'b1;
        repeat (4) @(posedge clk);
        probe(d, 1'b0);
        $display("protect test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== eeprom_ctl.sv ====
// data eeprom access controller: address, data, control, key, status, mask
// assumes an apb master on clk; a 256 x 8 array held inside
//
// Overview of operation
// (R01) software loads address, clears selects, sets read
// (R02) read byte in data register next cycle
// (R03) data held until read or software write
// (R04) software loads address and data first
// (R05) keys 55h then aah, then write strobe
// (R06) no write without exact key sequence
// (R07) write strobe blocked while permit clear
// (R08) hardware never clears permit
// (R09) clearing permit does not abort write
// (R10) write end clears strobe, sets done flag
// (R11) done flag sticky until software clears
// (R12) reads ignore the protect fuse
// (R13) software masks interrupts during unlock
// (R14) software keeps permit clear when idle
// (R15) array accessed one byte per address
// (R16) permit cleared at power-up
// (R17) writes blocked during power-up timer
// (R18) protect fuse denies external access
// (R19) read strobe clears itself after transfer
`timescale 1ns/1ns
`default_nettype none
module eeprom_ctl
    import eeprom_ctl_pkg::*;
#(
    parameter int unsigned WRITE_COUNT   = WRITE_CYCLES,
    parameter int unsigned POWERUP_COUNT = POWERUP_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              data_protect_fuse_n,
    input  wire logic              ext_req,
    input  wire logic [ADDR_W-1:0] ext_addr,
    output logic      [DATA_W-1:0] ext_rdata,
    output logic                   ext_denied,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = hit(a, OFS_ADDRESS) | hit(a, OFS_DATA) | hit(a, OFS_CONTROL)
              | hit(a, OFS_KEY) | hit(a, OFS_STATUS) | hit(a, OFS_MASK);
    endfunction

    logic acc;
    logic wr;
    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite;

    logic [ADDR_W-1:0] eeprom_address_low;
    logic [DATA_W-1:0] eeprom_data_low;
    ctrl_t             eeprom_control_one;
    key_state_t        key_state;
    logic              write_done_flag;
    logic              done_mask;
    logic [31:0]       write_cnt;
    logic [31:0]       pwr_cnt;
    logic              pwr_ok;
    logic [DATA_W-1:0] array_mem [DEPTH];
    logic              fuse_s1;
    logic              fuse_s2;
    logic              fuse_s3;
    logic              protect;
    logic              finish;
    logic              start_write;

    assign finish = eeprom_control_one.write_busy
                  & (write_cnt == WRITE_COUNT - 1);

    // strobe write accepted only armed, permitted and past power-up
    assign start_write = wr & hit(paddr, OFS_CONTROL)
                       & pwdata[BIT_WRITE]
                       & ~eeprom_control_one.write_busy
                       & (key_state == KEY_ARMED)              // [R05] [R06]
                       & eeprom_control_one.permit             // [R07]
                       & pwr_ok;                               // [R17]

    ////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known(paddr);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0;
        else if (psel & ~penable & ~pwrite)
        begin
            prdata <= 32'h0;
            if (hit(paddr, OFS_ADDRESS))
                prdata[ADDR_W-1:0] <= eeprom_address_low;
            else if (hit(paddr, OFS_DATA))
                prdata[DATA_W-1:0] <= eeprom_data_low;
            else if (hit(paddr, OFS_CONTROL))
            begin
                prdata[BIT_READ]   <= eeprom_control_one.read_req;
                prdata[BIT_WRITE]  <= eeprom_control_one.write_busy;
                prdata[BIT_PERMIT] <= eeprom_control_one.permit;
                prdata[BIT_CFG]    <= eeprom_control_one.cfg_sel;
                prdata[BIT_PROG]   <= eeprom_control_one.prog_sel;
            end
            else if (hit(paddr, OFS_STATUS))
                prdata[BIT_DONE] <= write_done_flag;
            else if (hit(paddr, OFS_MASK))
                prdata[BIT_DONE] <= done_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address register

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            eeprom_address_low <= '0;
        else if (wr & hit(paddr, OFS_ADDRESS))
            eeprom_address_low <= pwdata[ADDR_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////
    // unlock key sequence; any other register write in between disarms, reads do not

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            key_state <= KEY_IDLE;
        else if (wr)
        begin
            case (key_state)
                KEY_IDLE:
                    if (hit(paddr, OFS_KEY) && pwdata[7:0] == KEY_FIRST)
                        key_state <= KEY_GOT_FIRST;                // [R05]
                KEY_GOT_FIRST:
                    if (hit(paddr, OFS_KEY) && pwdata[7:0] == KEY_SECOND)
                        key_state <= KEY_ARMED;
                    else
                        key_state <= KEY_IDLE;                     // [R06]
                KEY_ARMED:
                    key_state <= KEY_IDLE;                         // [R06]
                default:
                    key_state <= KEY_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eeprom_control_one <= '0;                              // [R16]
        end
        else
        begin
            // permit changes only by software write
            if (wr & hit(paddr, OFS_CONTROL))                      // [R08]
            begin
                eeprom_control_one.permit   <= pwdata[BIT_PERMIT]; // [R09]
                eeprom_control_one.cfg_sel  <= pwdata[BIT_CFG];
                eeprom_control_one.prog_sel <= pwdata[BIT_PROG];
            end
            // read strobe set by software, dropped after the transfer
            if (wr & hit(paddr, OFS_CONTROL) & pwdata[BIT_READ])
                eeprom_control_one.read_req <= 1'b1;
            else
                eeprom_control_one.read_req <= 1'b0;               // [R19]
            if (start_write)
                eeprom_control_one.write_busy <= 1'b1;
            else if (finish)
                eeprom_control_one.write_busy <= 1'b0;             // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data register and array access

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            eeprom_data_low <= '0;
        else if (wr & hit(paddr, OFS_CONTROL) & pwdata[BIT_READ]
                 & ~pwdata[BIT_CFG] & ~pwdata[BIT_PROG]
                 & ~eeprom_control_one.write_busy)
            // no fuse check on core reads
            eeprom_data_low <= array_mem[eeprom_address_low]; // [R02] [R12]
        else if (wr & hit(paddr, OFS_DATA))
            eeprom_data_low <= pwdata[DATA_W-1:0];                 // [R03]
    end

    // byte wide array; committed at the end of the write time
    always_ff @(posedge clk)
    begin
        if (finish)
            array_mem[eeprom_address_low] <= eeprom_data_low;      // [R15]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            write_cnt <= '0;
        else if (start_write | finish)
            write_cnt <= '0;
        else if (eeprom_control_one.write_busy)
            write_cnt <= write_cnt + 32'd1;                        // [R09]
    end

    ////////////////////////////////////////////////////////////////////
    // power-up timer

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_cnt <= '0;
            pwr_ok  <= 1'b0;
        end
        else if (!pwr_ok)
        begin
            pwr_cnt <= pwr_cnt + 32'd1;
            pwr_ok  <= (pwr_cnt == POWERUP_COUNT - 1);             // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // external read path, denied under data protection

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fuse_s1 <= 1'b1;
            fuse_s2 <= 1'b1;
            fuse_s3 <= 1'b1;
            protect <= 1'b0;
        end
        else
        begin
            fuse_s1 <= data_protect_fuse_n;
            fuse_s2 <= fuse_s1;
            fuse_s3 <= fuse_s2;
            if (fuse_s2 == fuse_s3)
                protect <= ~fuse_s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_rdata  <= '0;
            ext_denied <= 1'b0;
        end
        else if (ext_req)
        begin
            ext_denied <= protect;                                 // [R18]
            ext_rdata  <= protect ? '0 : array_mem[ext_addr];      // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // done flag, mask, interrupt

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_done_flag <= 1'b0;
            done_mask       <= 1'b0;
            irq             <= 1'b0;
        end
        else
        begin
            if (finish)
                write_done_flag <= 1'b1;                           // [R10]
            else if (wr & hit(paddr, OFS_STATUS) & pwdata[BIT_DONE])
                write_done_flag <= 1'b0;                           // [R11]
            if (wr & hit(paddr, OFS_MASK))
                done_mask <= pwdata[BIT_DONE];
            irq <= write_done_flag & done_mask;                    // [R11]
        end
    end

endmodule
`default_nettype wire

// ==== eeprom_ctl_chk.sv ====
// port checker for the eeprom controller
// assumes binding to eeprom_ctl
`timescale 1ns/1ns
`default_nettype none
module eeprom_ctl_chk
    import eeprom_ctl_pkg::*;
#(
    parameter int unsigned WRITE_COUNT   = WRITE_CYCLES,
    parameter int unsigned POWERUP_COUNT = POWERUP_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        data_protect_fuse_n,
    input wire logic        ext_req,
    input wire logic [7:0]  ext_addr,
    input wire logic [7:0]  ext_rdata,
    input wire logic        ext_denied,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int unsigned up_cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            up_cnt <= 0;
        else if (up_cnt < POWERUP_COUNT + WRITE_COUNT)
            up_cnt <= up_cnt + 1;
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [7:0] a);
        setup_s ##0 !pwrite && paddr == a;
    endsequence
    a_ready_next: assert property (setup_s |=> pready && penable)
        else $error("pready missing in access cycle");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    a_err_unmapped: assert property (setup_s ##0 paddr > 8'h14 |=> pslverr)
        else $error("no error on unmapped");
    a_ok_mapped: assert property
        (setup_s ##0 paddr <= 8'h14 && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("error on mapped");
    a_unmapped_zero: assert property (rd_s(8'h18) |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_key_zero: assert property (rd_s(OFS_KEY) |=> prdata == 32'h0)
        else $error("key read not zero");
    a_read_self: assert property
        (rd_s(OFS_CONTROL) |=> !prdata[BIT_READ])
        else $error("read strobe still set");
    a_irq_late: assert property
        (irq |-> up_cnt >= POWERUP_COUNT + WRITE_COUNT)
        else $error("irq before any write could end");
    a_deny_zero: assert property (ext_denied |-> ext_rdata == 8'h00)
        else $error("denied access leaks data");
    a_deny_cause: assert property
        ($changed(ext_denied) |-> $past(ext_req))
        else $error("denied changed without request");
endmodule
bind eeprom_ctl eeprom_ctl_chk #(.WRITE_COUNT(WRITE_COUNT),
    .POWERUP_COUNT(POWERUP_COUNT)) i_eeprom_ctl_chk (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_protect_fuse_n(data_protect_fuse_n),
    .ext_req(ext_req), .ext_addr(ext_addr), .ext_rdata(ext_rdata),
    .ext_denied(ext_denied), .irq(irq));
`default_nettype wire

// ==== eeprom_ctl_pkg.sv ====
// package for the data eeprom access controller
// assumes a 32-bit apb master on the same clock
package eeprom_ctl_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH  = 256;

    // register byte addresses
    localparam logic [7:0] OFS_ADDRESS = 8'h00;
    localparam logic [7:0] OFS_DATA    = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_KEY     = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_MASK    = 8'h14;

    // control register bits
    localparam int unsigned BIT_READ    = 0;
    localparam int unsigned BIT_WRITE   = 1;
    localparam int unsigned BIT_PERMIT  = 2;
    localparam int unsigned BIT_CFG     = 6;
    localparam int unsigned BIT_PROG    = 7;
    // status and mask bits
    localparam int unsigned BIT_DONE    = 0;

    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // timing
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned WRITE_TIME_US = 2000;
    localparam int unsigned POWERUP_MS    = 64;
    localparam int unsigned WRITE_CYCLES  =
        (CLK_HZ / 1_000_000) * WRITE_TIME_US;
    localparam int unsigned POWERUP_CYCLES =
        (CLK_HZ / 1000) * POWERUP_MS;

    typedef enum logic [1:0]
    {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } key_state_t;

    typedef struct packed
    {
        logic                permit;
        logic                write_busy;
        logic                read_req;
        logic                cfg_sel;
        logic                prog_sel;
    } ctrl_t;

endpackage
